// >>> src/cas_multiframe_signaling.sv
/*
  Time slot 16 CAS multiframe logic of one E1 framer: receive alignment,
  alarms, signaling extraction with debounce, and transmit insertion.
  Assumes a byte-wide register port and byte strobes from the framer.
*/
// Behaviour
// RULE1: channels 1-15 ride slots 1-15, channels 16-30 ride slots 17-31.
// RULE2: frame 0 bit 6 of slot 16 is the multiframe alarm, one means alarm.
// RULE3: the three frame 0 spare bits are unused and normally one.
// RULE4: type 00 is clear channel from data highway, 01/10 CAS, 11 unused.
// RULE5: type 01 sends 1111 in place of any outgoing 0000 nibble.
// RULE6: select bit zero picks standard alignment, one picks enhanced.
// RULE7: standard aligns on 0000 preceded by a non-zero nibble.
// RULE8: enhanced aligns on 0000 after fifteen frames without 0000.
// RULE9: pattern error bit shows a bad 0000 pattern in frame 0.
// RULE10: loss on two missed patterns, sixteen zero slots, or frame loss.
// RULE11: loss sits at bit 2 of status, latch, mask, perf, fault; may mirror.
// RULE12: auto remote alarm sends Y as one during multiframe loss.
// RULE13: slot AIS on two multiframes of three or fewer zeros, bit 6.
// RULE14: slot RAI after three Y bits of one, reported at bit 4.
// RULE15: freeze all holds every transmit nibble in the buffer.
// RULE16: a cleared channel enable keeps its nibble; the cpu may rewrite it.
// RULE17: transmit regenerates the pattern; cpu reads highway spare and Y.
// RULE18: remote alarm control bit forces transmitted Y to one.
// RULE19: each spare comes from the highway if selected, else the buffer.
// RULE20: AIS insert sends all ones over the whole of slot 16.
// RULE21: receive buffer fills only once aligned; three places per bit.
// RULE22: debounce counts matches and moves the nibble at the threshold.
// RULE23: latched bits set on a rise until cleared; masked ones stay quiet.
`timescale 1ns/100ps
`default_nettype none
module cas_multiframe_signaling (
  input wire logic I_CLK, // 50 MHz system clock
  input wire logic I_RST_N, // synchronous reset, active low
  input wire logic [8:0] I_ADDR, // register offset
  input wire logic I_WR, // register write strobe
  input wire logic I_RD, // register read strobe
  input wire logic [7:0] I_WDATA, // register write data
  output logic [7:0] O_RDATA, // read data, cycle after I_RD
  input wire logic I_RX_TS16_VALID, // one received slot 16 byte
  input wire logic [7:0] I_RX_TS16_BYTE, // bit 7 is slot bit 1
  input wire logic I_RX_OOF, // basic frame alignment lost
  input wire logic I_TX_REQ, // framer wants the next slot 16 byte
  input wire logic [3:0] I_TX_FRAME, // multiframe frame of that byte
  output logic [7:0] O_TX_TS16_BYTE, // byte to send, cycle after request
  input wire logic [7:0] I_HWY_CLEAR_BYTE, // slot 16 from data highway
  input wire logic I_HWY_SIG_VALID, // highway nibble strobe
  input wire logic [4:0] I_HWY_SLOT, // slot of that nibble
  input wire logic [3:0] I_HWY_NIBBLE, // highway ABCD
  input wire logic I_HWY_F0_VALID, // highway frame 0 bits strobe
  input wire logic [3:0] I_HWY_F0_BITS, // x0, y, x1, x2
  input wire logic [4:0] I_RX_SLOT, // slot of receive nibble wanted
  output logic [3:0] O_RX_SIG_NIBBLE, // its main buffer nibble
  output logic O_MF_ALIGNED, // multiframe aligned
  output logic O_FRAME_LOSS_SUMMARY, // loss mirrored on frame loss
  output logic O_AIS_SUMMARY, // slot AIS mirrored on AIS
  output logic O_RAI_SUMMARY, // slot RAI mirrored on RAI
  output logic O_TX_FREEZE_IND, // transmit freeze indication
  output logic O_RX_FREEZE_IND, // receive freeze indication
  output logic O_ALARM_EVENT // unmasked latched alarm present
);
  typedef struct packed {
    cas_mf_pkg::align_state_t state;
    logic [3:0] rx_frame;
    logic [1:0] miss;
    logic prev_nz;
    logic [3:0] nz_run;
    logic [4:0] zero_run;
    logic pat_err;
    logic [3:0] ais_per;
    logic [2:0] ais_zeros;
    logic ais_low;
    logic ais_det;
    logic [1:0] rai_cnt;
    logic [7:0] stat_prev, latched, mask, perf, fault, fault_arm;
    logic [7:0] sig_ctrl;
    logic [3:0] deb_lim;
    logic [29:0] tx_en, rx_en;
    logic [2:0] spare_sel, spare_reg;
    logic algo, loss_en, merge, auto_y, ais_en, rai_en, force_y, ais_ins;
    logic [29:0][3:0] tx_buf, rx_main, rx_cur, rx_cnt;
    logic [3:0] hwy_f0;
    logic [7:0] tx_byte, rdata;
    logic [3:0] rx_nib;
    logic event_q;
  } state_t;

  state_t s_reg, s_next;
  logic mf_hunt;
  logic [7:0] alarm_st;
  logic [1:0] sig_type;

  // channel index of a slot; slot 16 carries the signaling itself
  function automatic logic [4:0] slot_ch(input logic [4:0] slot);
    slot_ch = (slot < 5'h10) ? slot - 5'h01 : slot - 5'h02; // RULE1
  endfunction : slot_ch

  function automatic logic slot_ok(input logic [4:0] slot);
    slot_ok = (slot != 5'h00) && (slot != 5'h10);
  endfunction : slot_ok

  // live alarm status, each gated by its enable
  assign mf_hunt = (s_reg.state == cas_mf_pkg::ALIGN_HUNT);
  assign sig_type = s_reg.sig_ctrl[7:6];
  always_comb begin
    alarm_st = 8'h00;
    alarm_st[cas_mf_pkg::ALM_LOSS] = s_reg.loss_en & mf_hunt; // RULE10 RULE11
    alarm_st[cas_mf_pkg::ALM_RAI] = s_reg.rai_en & (s_reg.rai_cnt == cas_mf_pkg::RAI_RUN); // RULE14
    alarm_st[cas_mf_pkg::ALM_AIS] = s_reg.ais_en & s_reg.ais_det; // RULE13
  end

  // next state of the whole block
  always_comb begin
    logic nz;
    logic low;
    logic [3:0] nib;
    logic [3:0] zc;
    logic [3:0] zsum;
    logic [4:0] ch;
    logic [4:0] fch;
    logic [4:0] hch;
    logic [7:0] clr;
    logic [7:0] rd;
    logic [31:0] en32;
    nz = 1'b0;
    low = 1'b0;
    nib = 4'h0;
    zc = 4'h0;
    zsum = 4'h0;
    ch = 5'h00;
    fch = 5'(({1'b0, I_ADDR[3:0]}) - 5'h01);
    hch = fch + cas_mf_pkg::CH_HALF;
    clr = 8'h00;
    rd = 8'h00;
    en32 = 32'h0;
    s_next = s_reg;
    // receive alignment, alarms and extraction, once per slot 16 byte
    if (I_RX_TS16_VALID) begin
      nz = |I_RX_TS16_BYTE[7:4];
      s_next.prev_nz = nz;
      if (!nz) s_next.nz_run = 4'h0;
      else if (s_reg.nz_run != cas_mf_pkg::ENH_RUN) s_next.nz_run = s_reg.nz_run + 4'h1;
      if (I_RX_TS16_BYTE != 8'h00) s_next.zero_run = 5'h00;
      else if (s_reg.zero_run != cas_mf_pkg::ZERO_FRAMES) begin
        s_next.zero_run = s_reg.zero_run + 5'h01;
      end
      case (s_reg.state)
        cas_mf_pkg::ALIGN_HUNT: begin
          // enhanced waits out a full run so a stray 0000 cannot lock
          if (!nz && (s_reg.algo ? (s_reg.nz_run == cas_mf_pkg::ENH_RUN) // RULE6 RULE8
                                 : s_reg.prev_nz)) begin // RULE7
            s_next.state = cas_mf_pkg::ALIGN_LOCKED;
            s_next.rx_frame = 4'h0;
            s_next.miss = 2'h0;
          end
        end
        cas_mf_pkg::ALIGN_LOCKED: begin
          s_next.rx_frame = s_reg.rx_frame + 4'h1;
          if (s_next.rx_frame == 4'h0) begin
            s_next.pat_err = nz; // RULE9
            s_next.miss = nz ? s_reg.miss + 2'h1 : 2'h0;
            if (s_next.miss == cas_mf_pkg::MISS_LIMIT) s_next.state = cas_mf_pkg::ALIGN_HUNT; // RULE10
            // y bit is slot bit 6, byte bit 2
            if (!I_RX_TS16_BYTE[cas_mf_pkg::F0_Y]) s_next.rai_cnt = 2'h0; // RULE2
            else if (s_reg.rai_cnt != cas_mf_pkg::RAI_RUN) s_next.rai_cnt = s_reg.rai_cnt + 2'h1; // RULE14
          end else if (sig_type != cas_mf_pkg::SIG_CLEAR && !I_RX_OOF
                       && !s_reg.sig_ctrl[cas_mf_pkg::SC_RX_FRZ]) begin
            for (int k = 0; k < 2; k++) begin
              ch = 5'({1'b0, s_next.rx_frame} - 5'h01); // RULE21
              if (k == 1) ch = ch + cas_mf_pkg::CH_HALF;
              nib = I_RX_TS16_BYTE[4*(1-k) +: 4];
              if (s_reg.rx_en[ch]) begin
                if (!s_reg.sig_ctrl[cas_mf_pkg::SC_DEB_EN]) s_next.rx_main[ch] = nib;
                else if (nib == s_reg.rx_cur[ch]) begin
                  if (s_reg.rx_cnt[ch] != cas_mf_pkg::CNT_MAX) begin
                    s_next.rx_cnt[ch] = s_reg.rx_cnt[ch] + 4'h1; // RULE22
                  end
                  if (s_next.rx_cnt[ch] >= s_reg.deb_lim) s_next.rx_main[ch] = s_reg.rx_cur[ch]; // RULE22
                end else begin
                  s_next.rx_cur[ch] = nib; // RULE22
                  s_next.rx_cnt[ch] = 4'h0;
                end
              end
            end
          end
        end
        default: s_next.state = cas_mf_pkg::ALIGN_HUNT;
      endcase
      if (s_next.zero_run == cas_mf_pkg::ZERO_FRAMES) s_next.state = cas_mf_pkg::ALIGN_HUNT; // RULE10
      // ais uses a free period so it works while unaligned
      zc = 4'($countones(~I_RX_TS16_BYTE));
      zsum = {1'b0, s_reg.ais_zeros} + zc;
      s_next.ais_zeros = (zsum > cas_mf_pkg::AIS_MAX_ZEROS) ? 3'(cas_mf_pkg::AIS_MAX_ZEROS + 4'h1)
                                                         : zsum[2:0];
      s_next.ais_per = s_reg.ais_per + 4'h1;
      if (s_reg.ais_per == cas_mf_pkg::MF_LAST) begin
        low = (zsum <= cas_mf_pkg::AIS_MAX_ZEROS);
        s_next.ais_det = low & s_reg.ais_low; // RULE13
        s_next.ais_low = low;
        s_next.ais_zeros = 3'h0;
        s_next.fault = alarm_st & s_reg.fault_arm; // RULE11
        s_next.fault_arm = alarm_st;
      end
    end
    if (I_RX_OOF) s_next.state = cas_mf_pkg::ALIGN_HUNT; // RULE10
    // event bits: set wins over a clear in the same cycle
    if (I_WR && I_ADDR == cas_mf_pkg::ADDR_ALARM_LATCH) clr = I_WDATA;
    s_next.stat_prev = alarm_st;
    s_next.latched = (s_reg.latched & ~clr) | (alarm_st & ~s_reg.stat_prev); // RULE23
    s_next.perf = ((I_RD && I_ADDR == cas_mf_pkg::ADDR_ALARM_PERF) ? 8'h00 : s_reg.perf)
                  | alarm_st; // RULE11
    s_next.event_q = |(s_reg.latched & ~s_reg.mask & cas_mf_pkg::ALARM_BITS); // RULE23
    // highway into the transmit buffer
    if (I_HWY_SIG_VALID && slot_ok(I_HWY_SLOT)) begin
      ch = slot_ch(I_HWY_SLOT);
      if (!s_reg.sig_ctrl[cas_mf_pkg::SC_TX_FRZ] && s_reg.tx_en[ch]) begin // RULE15 RULE16
        s_next.tx_buf[ch] = I_HWY_NIBBLE;
      end
    end
    if (I_HWY_F0_VALID) s_next.hwy_f0 = I_HWY_F0_BITS; // RULE17
    // register writes; a cpu write beats the highway in the same cycle
    if (I_WR) begin
      if (I_ADDR[8:4] == cas_mf_pkg::ROW_TX_BUF && I_ADDR[3:0] != 4'h0) begin
        s_next.tx_buf[fch] = I_WDATA[7:4]; // RULE16
        s_next.tx_buf[hch] = I_WDATA[3:0];
      end
      if (I_ADDR[8:4] == cas_mf_pkg::ROW_RX_MAIN && I_ADDR[3:0] != 4'h0) begin
        s_next.rx_main[fch] = I_WDATA[7:4];
        s_next.rx_main[hch] = I_WDATA[3:0];
      end
      if (I_ADDR[8:2] == cas_mf_pkg::ADDR_TX_EN[8:2]) begin
        en32 = {2'b00, s_reg.tx_en};
        en32[8*I_ADDR[1:0] +: 8] = I_WDATA;
        s_next.tx_en = en32[29:0];
      end
      if (I_ADDR[8:2] == cas_mf_pkg::ADDR_RX_EN[8:2]) begin
        en32 = {2'b00, s_reg.rx_en};
        en32[8*I_ADDR[1:0] +: 8] = I_WDATA;
        s_next.rx_en = en32[29:0];
      end
      case (I_ADDR)
        cas_mf_pkg::ADDR_MERGE: s_next.merge = I_WDATA[cas_mf_pkg::BIT_EN];
        cas_mf_pkg::ADDR_ALGO: s_next.algo = I_WDATA[cas_mf_pkg::BIT_ALGO];
        cas_mf_pkg::ADDR_LOSS_EN: s_next.loss_en = I_WDATA[cas_mf_pkg::BIT_LOSS_EN];
        cas_mf_pkg::ADDR_RAI_EN: s_next.rai_en = I_WDATA[cas_mf_pkg::BIT_EN];
        cas_mf_pkg::ADDR_AIS_EN: s_next.ais_en = I_WDATA[cas_mf_pkg::BIT_EN];
        cas_mf_pkg::ADDR_FORCE_Y: s_next.force_y = I_WDATA[cas_mf_pkg::BIT_FORCE_Y];
        cas_mf_pkg::ADDR_AIS_INS: s_next.ais_ins = I_WDATA[cas_mf_pkg::BIT_AIS_INS];
        cas_mf_pkg::ADDR_AUTO_Y: s_next.auto_y = I_WDATA[cas_mf_pkg::BIT_EN];
        cas_mf_pkg::ADDR_TX_MF_WORD: begin
          s_next.spare_reg = {I_WDATA[cas_mf_pkg::F0_X2], I_WDATA[cas_mf_pkg::F0_X1],
                              I_WDATA[cas_mf_pkg::F0_X0]};
        end
        cas_mf_pkg::ADDR_SPARE_SEL: s_next.spare_sel = I_WDATA[2:0];
        cas_mf_pkg::ADDR_DEB_LIMIT: s_next.deb_lim = I_WDATA[3:0];
        cas_mf_pkg::ADDR_SIG_CTRL: s_next.sig_ctrl = I_WDATA;
        cas_mf_pkg::ADDR_ALARM_MASK: s_next.mask = I_WDATA & cas_mf_pkg::ALARM_BITS;
        default: ;
      endcase
    end
    // register reads; unmapped offsets read zero
    if (I_ADDR[8:4] == cas_mf_pkg::ROW_TX_BUF && I_ADDR[3:0] != 4'h0) begin
      rd = {s_reg.tx_buf[fch], s_reg.tx_buf[hch]};
    end
    if (I_ADDR[8:4] == cas_mf_pkg::ROW_RX_MAIN && I_ADDR[3:0] != 4'h0) begin
      rd = {s_reg.rx_main[fch], s_reg.rx_main[hch]};
    end
    if (I_ADDR[8:2] == cas_mf_pkg::ADDR_TX_EN[8:2]) begin
      en32 = {2'b00, s_reg.tx_en};
      rd = en32[8*I_ADDR[1:0] +: 8];
    end
    if (I_ADDR[8:2] == cas_mf_pkg::ADDR_RX_EN[8:2]) begin
      en32 = {2'b00, s_reg.rx_en};
      rd = en32[8*I_ADDR[1:0] +: 8];
    end
    case (I_ADDR)
      cas_mf_pkg::ADDR_MERGE: rd[cas_mf_pkg::BIT_EN] = s_reg.merge;
      cas_mf_pkg::ADDR_ALGO: rd[cas_mf_pkg::BIT_ALGO] = s_reg.algo;
      cas_mf_pkg::ADDR_LOSS_EN: rd[cas_mf_pkg::BIT_LOSS_EN] = s_reg.loss_en;
      cas_mf_pkg::ADDR_RAI_EN: rd[cas_mf_pkg::BIT_EN] = s_reg.rai_en;
      cas_mf_pkg::ADDR_AIS_EN: rd[cas_mf_pkg::BIT_EN] = s_reg.ais_en;
      cas_mf_pkg::ADDR_FORCE_Y: rd[cas_mf_pkg::BIT_FORCE_Y] = s_reg.force_y;
      cas_mf_pkg::ADDR_AIS_INS: rd[cas_mf_pkg::BIT_AIS_INS] = s_reg.ais_ins;
      cas_mf_pkg::ADDR_AUTO_Y: rd[cas_mf_pkg::BIT_EN] = s_reg.auto_y;
      cas_mf_pkg::ADDR_PAT_ERR: rd[cas_mf_pkg::BIT_PAT_ERR] = s_reg.pat_err; // RULE9
      cas_mf_pkg::ADDR_TX_MF_WORD: rd = {4'h0, s_reg.hwy_f0}; // RULE17
      cas_mf_pkg::ADDR_SPARE_SEL: rd = {5'h00, s_reg.spare_sel};
      cas_mf_pkg::ADDR_DEB_LIMIT: rd = {4'h0, s_reg.deb_lim};
      cas_mf_pkg::ADDR_SIG_CTRL: rd = s_reg.sig_ctrl;
      cas_mf_pkg::ADDR_ALARM_STATUS: rd = alarm_st;
      cas_mf_pkg::ADDR_ALARM_LATCH: rd = s_reg.latched;
      cas_mf_pkg::ADDR_ALARM_MASK: rd = s_reg.mask;
      cas_mf_pkg::ADDR_ALARM_PERF: rd = s_reg.perf;
      cas_mf_pkg::ADDR_ALARM_FAULT: rd = s_reg.fault;
      default: ;
    endcase
    if (I_RD) s_next.rdata = rd;
    // transmit slot 16 byte, built on request
    if (I_TX_REQ) begin
      if (s_reg.ais_ins) s_next.tx_byte = cas_mf_pkg::TS16_AIS; // RULE20
      else if (sig_type == cas_mf_pkg::SIG_CLEAR) s_next.tx_byte = I_HWY_CLEAR_BYTE; // RULE4
      else if (I_TX_FRAME == 4'h0) begin
        s_next.tx_byte = 8'h00; // RULE17
        s_next.tx_byte[cas_mf_pkg::F0_X0] = s_reg.spare_sel[0] ? s_reg.hwy_f0[3] : s_reg.spare_reg[0]; // RULE19 RULE3
        s_next.tx_byte[cas_mf_pkg::F0_X1] = s_reg.spare_sel[1] ? s_reg.hwy_f0[1] : s_reg.spare_reg[1]; // RULE19
        s_next.tx_byte[cas_mf_pkg::F0_X2] = s_reg.spare_sel[2] ? s_reg.hwy_f0[0] : s_reg.spare_reg[2]; // RULE19
        s_next.tx_byte[cas_mf_pkg::F0_Y] = s_reg.force_y | (s_reg.auto_y & mf_hunt); // RULE12 RULE18
      end else begin
        for (int k = 0; k < 2; k++) begin
          ch = 5'({1'b0, I_TX_FRAME} - 5'h01); // RULE1
          if (k == 1) ch = ch + cas_mf_pkg::CH_HALF;
          nib = s_reg.tx_buf[ch];
          // a 0000 nibble would mimic the alignment pattern
          if (sig_type == cas_mf_pkg::SIG_CAS_SUB && nib == 4'h0) nib = cas_mf_pkg::NIB_SUB; // RULE5
          s_next.tx_byte[4*(1-k) +: 4] = nib;
        end
      end
    end
    s_next.rx_nib = slot_ok(I_RX_SLOT) ? s_reg.rx_main[slot_ch(I_RX_SLOT)] : 4'h0;
    if (!I_RST_N) begin
      s_next = '0;
      s_next.state = cas_mf_pkg::ALIGN_HUNT;
      s_next.spare_reg = cas_mf_pkg::SPARE_RST; // RULE3
      s_next.deb_lim = cas_mf_pkg::DEB_RST;
      s_next.tx_en = cas_mf_pkg::EN_RST;
      s_next.rx_en = cas_mf_pkg::EN_RST;
    end
  end

  // single state register
  always_ff @(posedge I_CLK) begin
    s_reg <= s_next;
  end

  // outputs decode the state register only; none reads an input
  assign O_RDATA = s_reg.rdata;
  assign O_TX_TS16_BYTE = s_reg.tx_byte;
  assign O_RX_SIG_NIBBLE = s_reg.rx_nib;
  assign O_MF_ALIGNED = !mf_hunt;
  assign O_FRAME_LOSS_SUMMARY = s_reg.merge & alarm_st[cas_mf_pkg::ALM_LOSS]; // RULE11
  assign O_AIS_SUMMARY = s_reg.merge & alarm_st[cas_mf_pkg::ALM_AIS];
  assign O_RAI_SUMMARY = s_reg.merge & alarm_st[cas_mf_pkg::ALM_RAI];
  assign O_TX_FREEZE_IND = s_reg.sig_ctrl[cas_mf_pkg::SC_TX_FRZ];
  assign O_RX_FREEZE_IND = s_reg.sig_ctrl[cas_mf_pkg::SC_RX_FRZ] | mf_hunt;
  assign O_ALARM_EVENT = s_reg.event_q;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_ais_all_ones: assert property (I_TX_REQ && s_reg.ais_ins |=> O_TX_TS16_BYTE == 8'hFF) // RULE20
    else $error("slot ais insert did not send all ones");
  a_clear_chan: assert property (I_TX_REQ && !s_reg.ais_ins && sig_type == 2'h0 // RULE4
    |=> O_TX_TS16_BYTE == $past(I_HWY_CLEAR_BYTE)) else $error("clear channel byte wrong");
  a_no_zero_nibble: assert property (I_TX_REQ && !s_reg.ais_ins && sig_type == 2'h1 // RULE5
    && I_TX_FRAME != 4'h0 |=> (|O_TX_TS16_BYTE[7:4]) && (|O_TX_TS16_BYTE[3:0]))
    else $error("zero nibble sent in type 01");
  a_mf_pattern_gen: assert property (I_TX_REQ && !s_reg.ais_ins && sig_type != 2'h0 // RULE17
    && I_TX_FRAME == 4'h0 |=> O_TX_TS16_BYTE[7:4] == 4'h0) else $error("pattern not regenerated");
  a_remote_y: assert property (I_TX_REQ && !s_reg.ais_ins && sig_type != 2'h0 // RULE12 RULE18
    && I_TX_FRAME == 4'h0 && (s_reg.force_y || (s_reg.auto_y && mf_hunt))
    |=> O_TX_TS16_BYTE[2]) else $error("y bit not forced");
  a_oof_loss: assert property (I_RX_OOF && s_reg.loss_en && !I_WR // RULE10
    |=> alarm_st[2] ##1 s_reg.latched[2] || $past(alarm_st[2], 2)) else $error("oof gave no loss");
  a_tx_freeze_hold: assert property (s_reg.sig_ctrl[0] && !I_WR // RULE15
    |=> s_reg.tx_buf == $past(s_reg.tx_buf)) else $error("frozen buffer changed");
  a_rx_hold_unaligned: assert property (mf_hunt && !I_WR // RULE21
    |=> s_reg.rx_main == $past(s_reg.rx_main)) else $error("receive buffer filled unaligned");
  a_latch_sticky: assert property (s_reg.latched[2] && !(I_WR && I_ADDR == 9'h165) // RULE23
    |=> s_reg.latched[2]) else $error("latched bit lost");
  a_rai_needs_three: assert property ($rose(s_reg.rai_cnt == 2'h3) // RULE14
    |-> $past(I_RX_TS16_VALID) && $past(I_RX_TS16_BYTE[2])) else $error("rai count without y bit");
endmodule : cas_multiframe_signaling
`default_nettype wire

// >>> pkg/cas_mf_pkg.sv
/*
  Constants for the time slot 16 channel associated signaling block:
  register offsets, field positions, reset values, counts and states.
  Assumes a byte-wide register port addressed by the printed offsets.
*/
package cas_mf_pkg;
  // register offsets
  localparam logic [8:0] ADDR_MERGE = 9'h000;
  localparam logic [8:0] ADDR_ALGO = 9'h001;
  localparam logic [8:0] ADDR_LOSS_EN = 9'h003;
  localparam logic [8:0] ADDR_RAI_EN = 9'h004;
  localparam logic [8:0] ADDR_AIS_EN = 9'h005;
  localparam logic [8:0] ADDR_FORCE_Y = 9'h006;
  localparam logic [8:0] ADDR_AIS_INS = 9'h007;
  localparam logic [8:0] ADDR_AUTO_Y = 9'h008;
  localparam logic [8:0] ADDR_PAT_ERR = 9'h018;
  localparam logic [4:0] ROW_RX_MAIN = 5'h08;
  localparam logic [4:0] ROW_TX_BUF = 5'h0D;
  localparam logic [8:0] ADDR_TX_MF_WORD = 9'h0D0;
  localparam logic [8:0] ADDR_SPARE_SEL = 9'h0E2;
  localparam logic [8:0] ADDR_RX_EN = 9'h0E8;
  localparam logic [8:0] ADDR_TX_EN = 9'h0EC;
  localparam logic [8:0] ADDR_DEB_LIMIT = 9'h0FE;
  localparam logic [8:0] ADDR_SIG_CTRL = 9'h134;
  localparam logic [8:0] ADDR_ALARM_STATUS = 9'h164;
  localparam logic [8:0] ADDR_ALARM_LATCH = 9'h165;
  localparam logic [8:0] ADDR_ALARM_MASK = 9'h166;
  localparam logic [8:0] ADDR_ALARM_PERF = 9'h167;
  localparam logic [8:0] ADDR_ALARM_FAULT = 9'h168;
  // field positions
  localparam int SC_TX_FRZ = 0;
  localparam int SC_RX_FRZ = 1;
  localparam int SC_DEB_EN = 4;
  localparam int ALM_LOSS = 2;
  localparam int ALM_RAI = 4;
  localparam int ALM_AIS = 6;
  localparam int BIT_EN = 0;
  localparam int BIT_LOSS_EN = 1;
  localparam int BIT_AIS_INS = 1;
  localparam int BIT_ALGO = 4;
  localparam int BIT_PAT_ERR = 4;
  localparam int BIT_FORCE_Y = 5;
  localparam int F0_X0 = 3;
  localparam int F0_Y = 2;
  localparam int F0_X1 = 1;
  localparam int F0_X2 = 0;
  localparam logic [7:0] ALARM_BITS = 8'h54;
  // signaling types
  localparam logic [1:0] SIG_CLEAR = 2'h0;
  localparam logic [1:0] SIG_CAS_SUB = 2'h1;
  // counts and fill patterns
  localparam logic [4:0] CH_HALF = 5'h0F;
  localparam logic [3:0] ENH_RUN = 4'hF;
  localparam logic [4:0] ZERO_FRAMES = 5'h10;
  localparam logic [1:0] MISS_LIMIT = 2'h2;
  localparam logic [3:0] AIS_MAX_ZEROS = 4'h3;
  localparam logic [1:0] RAI_RUN = 2'h3;
  localparam logic [3:0] MF_LAST = 4'hF;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [7:0] TS16_AIS = 8'hFF;
  localparam logic [3:0] NIB_SUB = 4'hF;
  // reset values
  localparam logic [2:0] SPARE_RST = 3'h7;
  localparam logic [3:0] DEB_RST = 4'hF;
  localparam logic [29:0] EN_RST = 30'h3FFFFFFF;
  typedef enum logic [0:0] {ALIGN_HUNT, ALIGN_LOCKED} align_state_t;
endpackage : cas_mf_pkg

// >>> tb/far_end_model.sv
/*
  Far side model: the E1 line framer that hands over received slot 16
  bytes and asks for the slot 16 byte to transmit.
  Assumes one system clock shared with the block.
*/
`timescale 1ns/100ps
`default_nettype none
module far_end_model (
  input wire logic clk, // system clock
  output logic rx_valid, // receive byte strobe
  output logic [7:0] rx_byte, // received slot 16 byte
  output logic tx_req, // transmit byte request
  output logic [3:0] tx_frame, // frame of the request
  input wire logic [7:0] tx_byte // byte returned by the block
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_req = 1'b0;
    tx_frame = 4'h0;
  end
  // the byte is inverted once the strobe drops, so a stale value never passes
  task automatic send_rx(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask : send_rx
  // answer is registered one cycle after the request edge
  task automatic ask_tx(input logic [3:0] f, output logic [7:0] b);
    @(posedge clk);
    tx_req <= 1'b1;
    tx_frame <= f;
    @(posedge clk);
    tx_req <= 1'b0;
    tx_frame <= ~f;
    #1 b = tx_byte;
  endtask : ask_tx
endmodule : far_end_model
`default_nettype wire

// >>> tb/tb_cas_multiframe_signaling.sv
/*
  Self-checking bench for the slot 16 signaling block.
  Assumes the far end model file is compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_cas_multiframe_signaling;
  logic clk, rst_n, wr, rd, rxv, txr, hv, aligned;
  logic oof, lsum, ev, txfi, rxfi;
  logic [4:0] rslot;
  logic [3:0] rnib;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, rxb, txb, got;
  logic [3:0] txf, hnib;
  logic [4:0] hslot;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial {rst_n, wr, rd, hv, oof, rslot, addr, wdata, hslot, hnib} = '0;
  cas_multiframe_signaling u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .I_RX_TS16_VALID(rxv),
    .I_RX_TS16_BYTE(rxb), .I_RX_OOF(oof), .I_TX_REQ(txr), .I_TX_FRAME(txf),
    .O_TX_TS16_BYTE(txb), .I_HWY_CLEAR_BYTE(8'hA5), .I_HWY_SIG_VALID(hv),
    .I_HWY_SLOT(hslot), .I_HWY_NIBBLE(hnib), .I_HWY_F0_VALID(1'b0),
    .I_HWY_F0_BITS(4'h0), .I_RX_SLOT(rslot), .O_RX_SIG_NIBBLE(rnib),
    .O_MF_ALIGNED(aligned), .O_FRAME_LOSS_SUMMARY(lsum), .O_AIS_SUMMARY(),
    .O_RAI_SUMMARY(), .O_TX_FREEZE_IND(txfi), .O_RX_FREEZE_IND(rxfi), .O_ALARM_EVENT(ev));
  far_end_model u_far (.clk(clk), .rx_valid(rxv), .rx_byte(rxb), .tx_req(txr),
    .tx_frame(txf), .tx_byte(txb));
  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data lands at the same edge that samples the strobe
  task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic hwy(input logic [4:0] s, input logic [3:0] n);
    @(posedge clk);
    {hv, hslot, hnib} <= {1'b1, s, n};
    @(posedge clk);
    hv <= 1'b0;
  endtask : hwy
  task automatic t_regs();
    rd_reg(9'h1FF, got);
    check("unmapped", 8'h00, got);
    rd_reg(cas_mf_pkg::ADDR_DEB_LIMIT, got);
    check("deb limit", 8'h0F, got & 8'h0F);
    wr_reg(cas_mf_pkg::ADDR_SIG_CTRL, 8'h40);
    rd_reg(cas_mf_pkg::ADDR_SIG_CTRL, got);
    check("sig ctrl", 8'h40, got);
  endtask : t_regs
  task automatic t_frame0();
    u_far.ask_tx(4'h0, got);
    check("frame0", 8'h0B, got);
    wr_reg(cas_mf_pkg::ADDR_FORCE_Y, 8'h20);
    u_far.ask_tx(4'h0, got);
    check("force y", 8'h0F, got);
    wr_reg(cas_mf_pkg::ADDR_FORCE_Y, 8'h00);
    wr_reg(cas_mf_pkg::ADDR_AIS_INS, 8'h02);
    u_far.ask_tx(4'h0, got);
    check("ais f0", 8'hFF, got);
    wr_reg(cas_mf_pkg::ADDR_AIS_INS, 8'h00);
  endtask : t_frame0
  task automatic t_nibbles();
    hwy(5'h03, 4'h0);
    hwy(5'h13, 4'h5);
    u_far.ask_tx(4'h3, got);
    check("frame3", 8'hF5, got);
    wr_reg(cas_mf_pkg::ADDR_SIG_CTRL, 8'h41);
    hwy(5'h13, 4'hA);
    u_far.ask_tx(4'h3, got);
    check("frozen", 8'hF5, got);
  endtask : t_nibbles
  task automatic t_align();
    u_far.send_rx(8'h55);
    u_far.send_rx(8'h00);
    #1 check("aligned", 8'h01, {7'h00, aligned});
  endtask : t_align
  // extraction once aligned; debounce holds a nibble until it repeats
  task automatic t_rx();
    u_far.send_rx(8'h5A);
    rslot <= 5'h11;
    @(posedge clk);
    #1 check("rx slot17", 8'h0A, {4'h0, rnib});
    check("freeze ind", 8'h01, {6'h00, rxfi, txfi});
    wr_reg(cas_mf_pkg::ADDR_DEB_LIMIT, 8'h01);
    wr_reg(cas_mf_pkg::ADDR_SIG_CTRL, 8'h51);
    u_far.send_rx(8'h3C);
    rslot <= 5'h02;
    @(posedge clk);
    #1 check("deb held", 8'h00, {4'h0, rnib});
    for (int f = 3; f <= 18; f++) u_far.send_rx((f == 16) ? 8'h0B : 8'h3C);
    @(posedge clk);
    #1 check("deb moved", 8'h03, {4'h0, rnib});
  endtask : t_rx
  // frame loss drops alignment and raises the loss alarm chain
  task automatic t_loss();
    wr_reg(cas_mf_pkg::ADDR_LOSS_EN, 8'h02);
    wr_reg(cas_mf_pkg::ADDR_MERGE, 8'h01);
    @(posedge clk);
    oof <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("loss outs", 8'h0E, {4'h0, lsum, ev, rxfi, aligned});
    rd_reg(cas_mf_pkg::ADDR_ALARM_LATCH, got);
    check("latched", 8'h04, got);
    wr_reg(cas_mf_pkg::ADDR_ALARM_MASK, 8'h04);
    @(posedge clk);
    #1 check("masked", 8'h00, {7'h00, ev});
  endtask : t_loss
  // ceiling well above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_frame0();
    t_nibbles();
    t_align();
    t_rx();
    t_loss();
    finish_test();
  end
endmodule : tb_cas_multiframe_signaling
`default_nettype wire
